// >>> common/rpfs_regs.svh
// register offsets, field positions, reset values and timing counts of the payload queue block
// assumes a 100 MHz system clock and byte-wide register access
//
// Operation
// - pipe four width: 0 unused, 1..32 bytes
// - pipe five width same; upper bits zero (code stores and reads back all eight bits as written)
// - resend flag set by resend, cleared by write/flush
// - resend last payload per enable pulse
// - status bit 5 shows transmit queue full
// - status bit 4 shows transmit empty, resets 1
// - status bit 1 shows receive queue full
// - status bit 0 shows receive empty, resets 1
// - ack payload loaded by command with pipe
// - three ack payloads pending, kept in order
// - transmit queue three entries, write only
// - receive queue three entries, command read
`ifndef RPFS_REGS_SVH
`define RPFS_REGS_SVH

`define RPFS_PIPE4_WIDTH_OFS 5'h15
`define RPFS_PIPE5_WIDTH_OFS 5'h16
`define RPFS_STATUS_OFS 5'h17
`define RPFS_WIDTH_RESET 8'h00
`define RPFS_STATUS_STORE_MASK 8'h8C
`define RPFS_STATUS_RESET 8'h00
`define RPFS_BIT_REUSE 6
`define RPFS_BIT_TX_FULL 5
`define RPFS_BIT_TX_EMPTY 4
`define RPFS_BIT_RX_FULL 1
`define RPFS_BIT_RX_EMPTY 0
`define RPFS_QUEUE_DEPTH 3
`define RPFS_CLK_PERIOD_NS 10
`define RPFS_CE_MIN_NS 10000
`define RPFS_CE_CYCLES ((`RPFS_CE_MIN_NS + `RPFS_CLK_PERIOD_NS - 1) / `RPFS_CLK_PERIOD_NS)

`endif

// >>> common/rpfs_pkg.sv
// types shared by the payload queue block
// assumes rpfs_regs.svh gives the numbers
package rpfs_pkg;

    // one payload: up to 32 bytes, its length and target pipe
    typedef struct packed {
        logic [255:0] data;
        logic [5:0] len;
        logic [2:0] pipe;
    } rpfs_pld_t;

    typedef enum logic [2:0] {
        RPFS_OP_WR_TX = 3'h0,
        RPFS_OP_WR_ACK = 3'h1,
        RPFS_OP_REUSE = 3'h2,
        RPFS_OP_FLUSH_TX = 3'h3,
        RPFS_OP_FLUSH_RX = 3'h4,
        RPFS_OP_RD_RX = 3'h5
    } rpfs_op_t;

    typedef struct packed {
        rpfs_op_t op;
        rpfs_pld_t pld;
    } rpfs_cmd_t;

    typedef enum logic [2:0] {
        RPFS_CE_IDLE = 3'h1,
        RPFS_CE_HOLD = 3'h2,
        RPFS_CE_DONE = 3'h4
    } rpfs_ce_state_t;

endpackage

// >>> core/rpfs_payload_fifo.sv
// three-entry payload queue with registered read data
// assumes push, pop and flush come from logic on clk_sys
`timescale 1ns/1ps
`include "rpfs_regs.svh"

module rpfs_payload_fifo (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // fill side
    input wire logic push,
    input wire rpfs_pkg::rpfs_pld_t pushData,
    input wire logic flush,
    // drain side, popData valid the cycle after pop
    input wire logic pop,
    output rpfs_pkg::rpfs_pld_t popData,
    // occupancy
    output logic full,
    output logic empty
);
    rpfs_pkg::rpfs_pld_t mem [`RPFS_QUEUE_DEPTH];
    rpfs_pkg::rpfs_pld_t next_mem [`RPFS_QUEUE_DEPTH];
    rpfs_pkg::rpfs_pld_t next_popData;
    logic [1:0] wrPtr, rdPtr, count;
    logic [1:0] next_wrPtr, next_rdPtr, next_count;
    logic doPush, doPop;

    function automatic logic [1:0] wrapInc(input logic [1:0] p);
        wrapInc = (p == 2'(`RPFS_QUEUE_DEPTH - 1)) ? 2'h0 : p + 2'h1;
    endfunction

    // flags straight from the count, so they move with the edge that changes it
    assign full = (count == 2'(`RPFS_QUEUE_DEPTH));
    assign empty = (count == 2'h0);
    assign doPush = push && !full && !flush;
    assign doPop = pop && !empty && !flush;

    always_comb begin
        next_mem = mem;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        next_popData = popData;
        if (flush) begin
            next_wrPtr = 2'h0;
            next_rdPtr = 2'h0;
            next_count = 2'h0;
        end else begin
            if (doPush) begin
                next_mem[wrPtr] = pushData;
                next_wrPtr = wrapInc(wrPtr);
            end
            if (doPop) begin
                next_popData = mem[rdPtr];
                next_rdPtr = wrapInc(rdPtr);
            end
            next_count = count + 2'(doPush) - 2'(doPop);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPtr <= 2'h0;
            rdPtr <= 2'h0;
            count <= 2'h0;
            popData <= '0;
            for (int i = 0; i < `RPFS_QUEUE_DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            popData <= next_popData;
            mem <= next_mem;
        end
    end

    a_full_drops_push: assert property (@(posedge clk_sys) disable iff (!resetn)
        full && push && !pop && !flush |=> full && $stable(wrPtr))
        else $error("push into full queue changed it");
    // checked pushes come two cycles apart; the cycle between may push or not
    sequence s_pushKept;
        push && !pop && !flush;
    endsequence
    sequence s_quiet;
        !pop && !flush;
    endsequence

    a_three_deep: assert property (@(posedge clk_sys) disable iff (!resetn)
        empty ##0 s_pushKept ##1 s_quiet ##1 s_pushKept ##1 s_quiet ##1 s_pushKept |=> full)
        else $error("queue not full after three pushes");
    a_flush_empties: assert property (@(posedge clk_sys) disable iff (!resetn)
        flush |=> empty && !full)
        else $error("flush left entries");

endmodule

// >>> core/rpfs_core.sv
// payload queues, status register and resend control of the radio
// assumes commands come decoded from the serial command unit on clk_sys;
// chipEnable is a pin and is synchronised here
`timescale 1ns/1ps
`include "rpfs_regs.svh"

module rpfs_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port, read data one cycle after the address
    input wire logic regWrite,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // decoded serial commands
    input wire logic cmdValid,
    output logic cmdReady,
    input wire rpfs_pkg::rpfs_cmd_t cmd,
    // receive payload out to the command unit
    output logic rxOutValid,
    input wire logic rxOutReady,
    output rpfs_pkg::rpfs_pld_t rxOutData,
    // radio side
    input wire logic chipEnable,
    input wire logic transmitterRole,
    output logic txSend,
    output rpfs_pkg::rpfs_pld_t txPayload,
    input wire logic rxPushValid,
    output logic rxPushReady,
    input wire rpfs_pkg::rpfs_pld_t rxPushData,
    input wire logic ackPop,
    output rpfs_pkg::rpfs_pld_t ackPayload,
    output logic ackPending,
    output logic [5:0] pipe4Width,
    output logic [5:0] pipe5Width
);
    //--------------------------------------------------------------------
    // register file
    //--------------------------------------------------------------------
    logic [7:0] pipe4Reg, pipe5Reg, statusStore, next_pipe4Reg, next_pipe5Reg, next_statusStore;
    logic [7:0] next_regRdData, statusView;
    logic reuse, next_reuse;
    logic txFull, txEmpty, rxFull, rxEmpty;
    logic cmdFire;

    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign cmdFire = cmdValid && cmdReady;
    assign pipe4Width = pipe4Reg[5:0];
    assign pipe5Width = pipe5Reg[5:0];

    always_comb begin
        statusView = statusStore;
        statusView[`RPFS_BIT_REUSE] = reuse;
        statusView[`RPFS_BIT_TX_FULL] = txFull;
        statusView[`RPFS_BIT_TX_EMPTY] = txEmpty;
        statusView[`RPFS_BIT_RX_FULL] = rxFull;
        statusView[`RPFS_BIT_RX_EMPTY] = rxEmpty;
        next_pipe4Reg = pipe4Reg;
        next_pipe5Reg = pipe5Reg;
        next_statusStore = statusStore;
        next_regRdData = 8'h00;
        if (regWrite && hit(regAddr, `RPFS_PIPE4_WIDTH_OFS)) begin
            next_pipe4Reg = regWrData;
        end
        if (regWrite && hit(regAddr, `RPFS_PIPE5_WIDTH_OFS)) begin
            next_pipe5Reg = regWrData;
        end
        if (regWrite && hit(regAddr, `RPFS_STATUS_OFS)) begin
            // only the spare bits take a write; flags are hardware owned
            next_statusStore = regWrData & `RPFS_STATUS_STORE_MASK;
        end
        if (hit(regAddr, `RPFS_PIPE4_WIDTH_OFS)) begin
            next_regRdData = pipe4Reg;
        end else if (hit(regAddr, `RPFS_PIPE5_WIDTH_OFS)) begin
            next_regRdData = pipe5Reg;
        end else if (hit(regAddr, `RPFS_STATUS_OFS)) begin
            next_regRdData = statusView;
        end
        // resend flag: commands arrive one at a time, so set and clear never meet
        next_reuse = reuse;
        if (cmdFire && cmd.op == rpfs_pkg::RPFS_OP_REUSE) begin
            next_reuse = 1'b1;
        end else if (cmdFire && (cmd.op == rpfs_pkg::RPFS_OP_WR_TX || cmd.op == rpfs_pkg::RPFS_OP_FLUSH_TX)) begin
            next_reuse = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pipe4Reg <= `RPFS_WIDTH_RESET;
            pipe5Reg <= `RPFS_WIDTH_RESET;
            statusStore <= `RPFS_STATUS_RESET;
            regRdData <= 8'h00;
            reuse <= 1'b0;
        end else begin
            pipe4Reg <= next_pipe4Reg;
            pipe5Reg <= next_pipe5Reg;
            statusStore <= next_statusStore;
            regRdData <= next_regRdData;
            reuse <= next_reuse;
        end
    end

    //--------------------------------------------------------------------
    // payload queues
    //--------------------------------------------------------------------
    logic txPop, rxPop, txPopd, rxPend, ackEmptyW;
    logic [1:0] bufCount;
    rpfs_pkg::rpfs_pld_t txPopData, rxPopData;
    logic isOp [6];

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            isOp[i] = cmdFire && (cmd.op == rpfs_pkg::rpfs_op_t'(3'(i)));
        end
    end

    // a receive read waits until the out buffer can take the word in flight
    assign cmdReady = (cmd.op != rpfs_pkg::RPFS_OP_RD_RX) || (2'(bufCount + 2'(rxPend)) < 2'h2);
    assign rxPop = isOp[rpfs_pkg::RPFS_OP_RD_RX] && !rxEmpty;
    assign rxPushReady = !rxFull;
    assign ackPending = !ackEmptyW;

    rpfs_payload_fifo txQueue (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .push(isOp[rpfs_pkg::RPFS_OP_WR_TX]),
        .pushData(cmd.pld),
        .flush(isOp[rpfs_pkg::RPFS_OP_FLUSH_TX]),
        .pop(txPop),
        .popData(txPopData),
        .full(txFull),
        .empty(txEmpty)
    );

    rpfs_payload_fifo rxQueue (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .push(rxPushValid),
        .pushData(rxPushData),
        .flush(isOp[rpfs_pkg::RPFS_OP_FLUSH_RX]),
        .pop(rxPop),
        .popData(rxPopData),
        .full(rxFull),
        .empty(rxEmpty)
    );

    // one shared queue keeps every pipe's payloads in arrival order
    rpfs_payload_fifo ackQueue (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .push(isOp[rpfs_pkg::RPFS_OP_WR_ACK]),
        .pushData(cmd.pld),
        .flush(1'b0),
        .pop(ackPop),
        .popData(ackPayload),
        .full(),
        .empty(ackEmptyW)
    );

    //--------------------------------------------------------------------
    // two-entry out buffer for receive reads
    //--------------------------------------------------------------------
    rpfs_pkg::rpfs_pld_t outBuf [2];
    rpfs_pkg::rpfs_pld_t next_outBuf [2];
    logic [1:0] next_bufCount;
    logic outTake;

    assign rxOutValid = (bufCount != 2'h0);
    assign rxOutData = outBuf[0];
    assign outTake = rxOutValid && rxOutReady;

    always_comb begin
        next_outBuf = outBuf;
        next_bufCount = bufCount;
        if (outTake) begin
            next_outBuf[0] = outBuf[1];
            next_bufCount = bufCount - 2'h1;
        end
        if (rxPend) begin
            next_outBuf[next_bufCount[0]] = rxPopData;
            next_bufCount = next_bufCount + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            outBuf[0] <= '0;
            outBuf[1] <= '0;
            bufCount <= 2'h0;
            rxPend <= 1'b0;
        end else begin
            outBuf <= next_outBuf;
            bufCount <= next_bufCount;
            rxPend <= rxPop;
        end
    end

    //--------------------------------------------------------------------
    // chip enable timing and (re)send
    //--------------------------------------------------------------------
    logic ceMeta, ceSync, fire;
    logic [9:0] ceCount, next_ceCount;
    rpfs_pkg::rpfs_ce_state_t ceState, next_ceState;
    rpfs_pkg::rpfs_pld_t next_txPayload;
    logic next_txSend;

    assign fire = (ceState == rpfs_pkg::RPFS_CE_HOLD) && ceSync
        && (ceCount == 10'(`RPFS_CE_CYCLES - 1)) && transmitterRole;
    assign txPop = fire && !reuse && !txEmpty;

    always_comb begin
        next_ceState = ceState;
        next_ceCount = ceCount;
        unique case (ceState)
            rpfs_pkg::RPFS_CE_IDLE: begin
                next_ceCount = 10'h000;
                if (ceSync) begin
                    next_ceState = rpfs_pkg::RPFS_CE_HOLD;
                end
            end
            rpfs_pkg::RPFS_CE_HOLD: begin
                next_ceCount = ceCount + 10'h001;
                if (!ceSync) begin
                    next_ceState = rpfs_pkg::RPFS_CE_IDLE;
                end else if (ceCount == 10'(`RPFS_CE_CYCLES - 1)) begin
                    next_ceState = rpfs_pkg::RPFS_CE_DONE;
                end
            end
            rpfs_pkg::RPFS_CE_DONE: begin
                // one send per enable pulse: wait for the pin to drop
                if (!ceSync) begin
                    next_ceState = rpfs_pkg::RPFS_CE_IDLE;
                end
            end
            default: begin
                next_ceState = rpfs_pkg::RPFS_CE_IDLE;
            end
        endcase
        next_txSend = (fire && reuse) || txPopd;
        next_txPayload = txPopd ? txPopData : txPayload;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ceMeta <= 1'b0;
            ceSync <= 1'b0;
            ceState <= rpfs_pkg::RPFS_CE_IDLE;
            ceCount <= 10'h000;
            txPopd <= 1'b0;
            txSend <= 1'b0;
            txPayload <= '0;
        end else begin
            ceMeta <= chipEnable;
            ceSync <= ceMeta;
            ceState <= next_ceState;
            ceCount <= next_ceCount;
            txPopd <= txPop;
            txSend <= next_txSend;
            txPayload <= next_txPayload;
        end
    end

    //--------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------
    sequence s_resendFire;
        fire && reuse;
    endsequence

    a_resend_sends: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_resendFire |=> txSend && $stable(txPayload))
        else $error("resend did not repeat the last payload");
    a_resend_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        fire |-> ceSync && $past(ceSync, `RPFS_CE_CYCLES - 1))
        else $error("send before the enable was held long enough");
    a_reuse_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmd.op == rpfs_pkg::RPFS_OP_REUSE
        |=> reuse ##1 regRdData[6] == 1'b1 || !$past(hit(regAddr, `RPFS_STATUS_OFS)))
        else $error("resend flag not set");
    a_reuse_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmd.op == rpfs_pkg::RPFS_OP_FLUSH_TX |=> !reuse && txEmpty)
        else $error("flush left resend flag or data");
    a_tx_full_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        hit(regAddr, `RPFS_STATUS_OFS) |=> regRdData[5] == $past(txFull) && regRdData[4] == $past(txEmpty))
        else $error("status read disagrees with transmit occupancy");
    a_rx_flags_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        hit(regAddr, `RPFS_STATUS_OFS) |=> regRdData[1] == $past(rxFull) && regRdData[0] == $past(rxEmpty))
        else $error("status read disagrees with receive occupancy");
    a_width_store: assert property (@(posedge clk_sys) disable iff (!resetn)
        regWrite && hit(regAddr, `RPFS_PIPE5_WIDTH_OFS) |=> pipe5Width == $past(regWrData[5:0]))
        else $error("pipe width not stored");
    a_rx_read_path: assert property (@(posedge clk_sys) disable iff (!resetn)
        rxPop |=> rxPend ##1 rxOutValid)
        else $error("receive read did not reach the out buffer");

endmodule

// >>> dv/rpfs_radio_model.sv
// radio side stand-in: loads receive payloads, pops ack payloads, counts sends
// assumes the bench calls its tasks; nothing else drives these pins
`timescale 1ns/1ps
module rpfs_radio_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // core radio pins
    input wire logic txSend,
    input wire logic rxPushReady,
    output logic rxPushValid,
    output rpfs_pkg::rpfs_pld_t rxPushData,
    output logic ackPop
);
    int sendCount = 0;
    initial begin
        rxPushValid = 1'b0;
        rxPushData = '0;
        ackPop = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (resetn && txSend === 1'b1) begin
            sendCount++;
        end
    end
    // idle data is inverted so a stale word never passes for a fresh one
    task automatic push(input rpfs_pkg::rpfs_pld_t p);
        @(negedge clk_sys);
        rxPushValid = 1'b1;
        rxPushData = p;
        #1;
        for (int i = 0; i < 20 && rxPushReady !== 1'b1; i++) @(negedge clk_sys);
        @(negedge clk_sys);
        rxPushValid = 1'b0;
        rxPushData = ~p;
    endtask
    task automatic popAck();
        @(negedge clk_sys);
        ackPop = 1'b1;
        @(negedge clk_sys);
        ackPop = 1'b0;
    endtask
endmodule

// >>> dv/tb_radio_payload_fifo_status.sv
// self-checking bench of the payload queue core
// assumes rpfs_radio_model stands at the radio pins
`timescale 1ns/1ps
`include "rpfs_regs.svh"
module tb_radio_payload_fifo_status;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic regWrite = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic cmdValid = 1'b0;
    logic cmdReady;
    rpfs_pkg::rpfs_cmd_t cmd = '0;
    logic rxOutValid;
    logic rxOutReady = 1'b0;
    rpfs_pkg::rpfs_pld_t rxOutData;
    logic chipEnable = 1'b0;
    logic transmitterRole = 1'b0;
    logic txSend;
    rpfs_pkg::rpfs_pld_t txPayload;
    logic rxPushValid;
    logic rxPushReady;
    rpfs_pkg::rpfs_pld_t rxPushData;
    logic ackPop;
    rpfs_pkg::rpfs_pld_t ackPayload;
    logic ackPending;
    logic [5:0] pipe4Width;
    logic [5:0] pipe5Width;
    int errorCnt = 0;
    int checkCount = 0;

    rpfs_core uut (.clk_sys(clk_sys), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmd(cmd), .rxOutValid(rxOutValid), .rxOutReady(rxOutReady), .rxOutData(rxOutData),
        .chipEnable(chipEnable), .transmitterRole(transmitterRole), .txSend(txSend),
        .txPayload(txPayload), .rxPushValid(rxPushValid), .rxPushReady(rxPushReady),
        .rxPushData(rxPushData), .ackPop(ackPop), .ackPayload(ackPayload), .ackPending(ackPending),
        .pipe4Width(pipe4Width), .pipe5Width(pipe5Width));
    rpfs_radio_model radio (.clk_sys(clk_sys), .resetn(resetn), .txSend(txSend),
        .rxPushReady(rxPushReady), .rxPushValid(rxPushValid), .rxPushData(rxPushData), .ackPop(ackPop));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    function automatic rpfs_pkg::rpfs_pld_t mk(input logic [7:0] n);
        mk.data = {32{n}};
        mk.len = 6'h20;
        mk.pipe = n[2:0];
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checkCount++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkp(input rpfs_pkg::rpfs_pld_t g, input rpfs_pkg::rpfs_pld_t e);
        checkCount++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        regAddr = a;
        @(negedge clk_sys);
        chk8(regRdData, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regWrite = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk_sys);
        regWrite = 1'b0;
    endtask
    // waiting on ready keeps a full out buffer from swallowing the read
    task automatic docmd(input rpfs_pkg::rpfs_op_t o, input rpfs_pkg::rpfs_pld_t p);
        int i;
        @(negedge clk_sys);
        cmdValid = 1'b1;
        cmd.op = o;
        cmd.pld = p;
        #1;
        for (i = 0; i < 20 && cmdReady !== 1'b1; i++) @(negedge clk_sys);
        if (i == 20) begin
            errorCnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, cmdReady, 1'b1);
        end
        @(negedge clk_sys);
        cmdValid = 1'b0;
    endtask
    task automatic send(input rpfs_pkg::rpfs_pld_t e, input logic want);
        int i;
        int n0;
        n0 = radio.sendCount;
        @(negedge clk_sys);
        chipEnable = 1'b1;
        for (i = 0; i < 1100 && txSend !== 1'b1; i++) @(negedge clk_sys);
        chk8({7'h00, txSend === 1'b1 && i >= `RPFS_CE_CYCLES}, {7'h00, want});
        if (want) chkp(txPayload, e);
        @(negedge clk_sys);
        chipEnable = 1'b0;
        chk8(8'(radio.sendCount - n0), {7'h00, want});
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic drain(input rpfs_pkg::rpfs_pld_t e);
        @(negedge clk_sys);
        for (int i = 0; i < 20 && rxOutValid !== 1'b1; i++) @(negedge clk_sys);
        chkp(rxOutData, e);
        rxOutReady = 1'b1;
        @(negedge clk_sys);
        rxOutReady = 1'b0;
    endtask
    task automatic endOfTest();
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #200000;
        errorCnt++;
        $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        endOfTest();
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        rd(`RPFS_STATUS_OFS, 8'h11);
        rd(`RPFS_PIPE4_WIDTH_OFS, 8'h00);
        rd(`RPFS_PIPE5_WIDTH_OFS, 8'h00);
        wr(`RPFS_PIPE4_WIDTH_OFS, 8'h20);
        wr(`RPFS_PIPE5_WIDTH_OFS, 8'h01);
        rd(`RPFS_PIPE4_WIDTH_OFS, 8'h20);
        rd(`RPFS_PIPE5_WIDTH_OFS, 8'h01);
        chk8({2'h0, pipe4Width}, 8'h20);
        chk8({2'h0, pipe5Width}, 8'h01);
        rd(5'h1F, 8'h00);
        // flag bits ignore writes; reserved bits kept zero
        wr(`RPFS_STATUS_OFS, 8'h73);
        rd(`RPFS_STATUS_OFS, 8'h11);
        $display("test registers done");
        for (int k = 1; k <= 4; k++) docmd(rpfs_pkg::RPFS_OP_WR_TX, mk(8'(k)));
        rd(`RPFS_STATUS_OFS, 8'h21);
        transmitterRole = 1'b1;
        send(mk(8'h01), 1'b1);
        docmd(rpfs_pkg::RPFS_OP_REUSE, mk(8'h00));
        rd(`RPFS_STATUS_OFS, 8'h41);
        send(mk(8'h01), 1'b1);
        transmitterRole = 1'b0;
        send(mk(8'h01), 1'b0);
        transmitterRole = 1'b1;
        docmd(rpfs_pkg::RPFS_OP_FLUSH_TX, mk(8'h00));
        rd(`RPFS_STATUS_OFS, 8'h11);
        docmd(rpfs_pkg::RPFS_OP_WR_TX, mk(8'h09));
        docmd(rpfs_pkg::RPFS_OP_REUSE, mk(8'h00));
        docmd(rpfs_pkg::RPFS_OP_WR_TX, mk(8'h0A));
        rd(`RPFS_STATUS_OFS, 8'h01);
        send(mk(8'h09), 1'b1);
        docmd(rpfs_pkg::RPFS_OP_FLUSH_TX, mk(8'h00));
        $display("test transmit done");
        transmitterRole = 1'b0;
        for (int k = 1; k <= 3; k++) radio.push(mk(8'(8'h10 + k)));
        rd(`RPFS_STATUS_OFS, 8'h12);
        chk8({7'h00, rxPushReady}, 8'h00);
        docmd(rpfs_pkg::RPFS_OP_RD_RX, mk(8'h00));
        docmd(rpfs_pkg::RPFS_OP_RD_RX, mk(8'h00));
        // two words parked in the out buffer, a third read must wait
        repeat (3) @(negedge clk_sys);
        cmdValid = 1'b1;
        #1;
        chk8({7'h00, cmdReady}, 8'h00);
        @(negedge clk_sys);
        cmdValid = 1'b0;
        drain(mk(8'h11));
        drain(mk(8'h12));
        docmd(rpfs_pkg::RPFS_OP_RD_RX, mk(8'h00));
        drain(mk(8'h13));
        rd(`RPFS_STATUS_OFS, 8'h11);
        radio.push(mk(8'h14));
        rd(`RPFS_STATUS_OFS, 8'h10);
        docmd(rpfs_pkg::RPFS_OP_FLUSH_RX, mk(8'h00));
        rd(`RPFS_STATUS_OFS, 8'h11);
        $display("test receive done");
        for (int k = 1; k <= 4; k++) docmd(rpfs_pkg::RPFS_OP_WR_ACK, mk(8'(8'h20 + 8 * k)));
        chk8({7'h00, ackPending}, 8'h01);
        for (int k = 1; k <= 3; k++) begin
            radio.popAck();
            chkp(ackPayload, mk(8'(8'h20 + 8 * k)));
        end
        chk8({7'h00, ackPending}, 8'h00);
        $display("test ack done");
        endOfTest();
    end
endmodule
